// ### core/debounced_input_serializer.sv
// eight-channel debounced input serializer core
// How it works
// - input accepted only after full stable interval
// - select pins choose 3 ms, 1 ms, bypass
// - load low copies filtered bits into stages
// - shift on enabled serial clock rising edge
// - load high blocks filtered inputs from register
// - enable high freezes register despite clock
// - shift toward output, serial input enters first
// - eight stages, output shows last stage
// - first trip point drives temp ok low
// - second trip point three-states serial out and temp ok
// - temp ok still reads low in shutdown
`timescale 1ns/1ps
module debounced_input_serializer
    import dis_pkg::*;
#(
    parameter int          DB_LONG   = DB_LONG_CYC,
    parameter int          DB_SHORT  = DB_SHORT_CYC,
    parameter bit          MSB_FIRST = 1'b1
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // field side
    input  wire logic [7:0]  field_inputs_i,
    input  wire logic        debounce_select_low_i,
    input  wire logic        debounce_select_high_i,
    // serial controller side
    input  wire serial_ctl_t ctl_i,
    output logic             serial_out_o,
    output logic             serial_out_oe_o,
    // thermal sensor
    input  wire thermal_t    thermal_i,
    output logic             temp_ok_n_o,
    output logic             temp_ok_n_oe_o,
    // register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    output logic             irq_o
);

    initial begin
        if (DB_LONG < 1 || DB_SHORT < 1 || DB_LONG >= (1 << DB_CNT_W)
            || DB_SHORT > DB_LONG) begin
            $error("debounce counts out of range");
        end
    end

    // --------------------------------------------------------------
    // synchronisers
    // --------------------------------------------------------------
    logic [7:0]  field_s1_r;
    logic [7:0]  field_s2_r;
    logic [1:0]  sel_s1_r;
    logic [1:0]  sel_s2_r;
    logic [3:0]  ctl_s1_r;
    logic [3:0]  ctl_s2_r;
    logic [1:0]  therm_s1_r;
    logic [1:0]  therm_s2_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            field_s1_r <= 8'h00;
            field_s2_r <= 8'h00;
            sel_s1_r   <= 2'h3;
            sel_s2_r   <= 2'h3;
            ctl_s1_r   <= 4'hA;
            ctl_s2_r   <= 4'hA;
            therm_s1_r <= 2'h0;
            therm_s2_r <= 2'h0;
        end else begin
            field_s1_r <= field_inputs_i;
            field_s2_r <= field_s1_r;
            sel_s1_r   <= {debounce_select_high_i, debounce_select_low_i};
            sel_s2_r   <= sel_s1_r;
            ctl_s1_r   <= ctl_i;
            ctl_s2_r   <= ctl_s1_r;
            therm_s1_r <= thermal_i;
            therm_s2_r <= therm_s1_r;
        end
    end

    logic load_n;
    logic sclk;
    logic enable_n;
    logic sdata;
    logic over_temp;
    logic shutdown;

    assign load_n    = ctl_s2_r[3];
    assign sclk      = ctl_s2_r[2];
    assign enable_n  = ctl_s2_r[1];
    assign sdata     = ctl_s2_r[0];
    assign over_temp = therm_s2_r[1];
    assign shutdown  = therm_s2_r[0];

    // --------------------------------------------------------------
    // debounce filter
    // --------------------------------------------------------------
    logic [DB_CNT_W-1:0] db_limit;

    // reserved code behaves as the longest interval, the safe choice
    always_comb begin
        unique case (sel_s2_r)
            DB_SEL_3MS:    db_limit = DB_CNT_W'(DB_LONG);
            DB_SEL_1MS:    db_limit = DB_CNT_W'(DB_SHORT);
            DB_SEL_BYPASS: db_limit = '0;
            default:       db_limit = DB_CNT_W'(DB_LONG);
        endcase
    end

    logic [DB_CNT_W-1:0] db_cnt_r [CHANNELS];
    logic [7:0]          filtered_channel_bits_r;
    logic [7:0]          filt_change;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            filtered_channel_bits_r <= FILT_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                db_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (field_s2_r[i] == filtered_channel_bits_r[i]) begin
                    db_cnt_r[i] <= '0;
                end else if (db_cnt_r[i] + 1'b1 >= db_limit) begin
                    db_cnt_r[i] <= '0;
                    filtered_channel_bits_r[i] <= field_s2_r[i];
                end else begin
                    db_cnt_r[i] <= db_cnt_r[i] + 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            filt_change[i] = (field_s2_r[i] != filtered_channel_bits_r[i])
                             && (db_cnt_r[i] + 1'b1 >= db_limit);
        end
    end

    // --------------------------------------------------------------
    // shift register
    // --------------------------------------------------------------
    logic       sclk_d_r;
    logic       shift_ev;
    logic [7:0] shift_r;
    logic [7:0] load_word;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
        end
    end

    assign shift_ev = sclk && !sclk_d_r && load_n && !enable_n;
    // channel 7 nearest the output unless reversed
    assign load_word = MSB_FIRST ? filtered_channel_bits_r
                                 : {<<{filtered_channel_bits_r}};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_r <= SHIFT_RESET;
        end else if (!load_n) begin
            shift_r <= load_word;
        end else if (shift_ev) begin
            shift_r <= {shift_r[6:0], sdata};
        end
    end

    // --------------------------------------------------------------
    // pins and thermal
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
            temp_ok_n_o     <= 1'b0;
            temp_ok_n_oe_o  <= 1'b0;
        end else begin
            serial_out_o    <= shift_r[7];
            serial_out_oe_o <= !shutdown;
            // pin undriven in shutdown; bench pull-down reads low
            temp_ok_n_o     <= !(over_temp || shutdown);
            temp_ok_n_oe_o  <= !shutdown;
        end
    end

    // --------------------------------------------------------------
    // interrupts and registers
    // --------------------------------------------------------------
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] events;
    logic       ot_d_r;
    logic       sd_d_r;
    logic       clr_status;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ot_d_r <= 1'b0;
            sd_d_r <= 1'b0;
        end else begin
            ot_d_r <= over_temp;
            sd_d_r <= shutdown;
        end
    end

    assign events     = {shutdown && !sd_d_r, over_temp && !ot_d_r, |filt_change};
    assign clr_status = reg_rd_i && (reg_addr_i == REG_STATUS);

    // a new event beats the read-clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_r <= 3'h0;
        end else begin
            status_r <= (clr_status ? 3'h0 : status_r) | events;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_r <= MASK_RESET;
        end else if (reg_wr_i && reg_addr_i == REG_MASK) begin
            mask_r <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_STATUS:   reg_rdata_o <= {5'h00, status_r};
                REG_MASK:     reg_rdata_o <= {5'h00, mask_r};
                REG_CHANNELS: reg_rdata_o <= filtered_channel_bits_r;
                default:      reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((((clr_status ? 3'h0 : status_r) | events)) & mask_r);
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    sequence s_enabled_edge;
        load_n && !enable_n && sclk && !sclk_d_r;
    endsequence

    a_load_copies: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !load_n |=> shift_r == $past(load_word))
        else $error("load did not copy filtered bits");

    a_shift_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_enabled_edge |=> shift_r == {$past(shift_r[6:0]), $past(sdata)})
        else $error("shift did not move one stage");

    a_hold_disabled: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (load_n && enable_n) |=> $stable(shift_r))
        else $error("register changed while disabled");

    a_out_last: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> serial_out_o == $past(shift_r[7]))
        else $error("serial output not last stage");

    a_temp_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        over_temp |=> !temp_ok_n_o)
        else $error("temp ok not low at trip");

    a_shutdown_hiz: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        shutdown |=> !serial_out_oe_o && !temp_ok_n_oe_o && !temp_ok_n_o)
        else $error("outputs driven in shutdown");

    a_bypass_fast: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (sel_s2_r == DB_SEL_BYPASS && field_s2_r[0] != filtered_channel_bits_r[0])
        |=> filtered_channel_bits_r[0] == $past(field_s2_r[0]))
        else $error("bypass did not pass input");

    a_filter_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (field_s2_r[0] == filtered_channel_bits_r[0]) |=> db_cnt_r[0] == '0)
        else $error("counter not restarted");

    // a differing level must not be taken before its count is full
    a_filter_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (field_s2_r[0] != filtered_channel_bits_r[0] && db_cnt_r[0] + 1'b1 < db_limit)
        |=> $stable(filtered_channel_bits_r[0]))
        else $error("level accepted too early");

    a_load_blocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (load_n && !shift_ev) |=> $stable(shift_r))
        else $error("register changed without load or shift");

    a_out_driven: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !shutdown |=> serial_out_oe_o && temp_ok_n_oe_o)
        else $error("outputs not driven while cool");

    a_temp_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!over_temp && !shutdown) |=> temp_ok_n_o)
        else $error("temp ok low without fault");

    // -------- status, mask and read port --------
    sequence s_status_read;
        reg_rd_i && reg_addr_i == REG_STATUS;
    endsequence

    a_status_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (events != 3'h0) |=> (status_r & $past(events)) == $past(events))
        else $error("event did not set status");

    a_read_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (s_status_read ##0 (events == 3'h0)) |=> status_r == 3'h0)
        else $error("status read did not clear");

    a_mask_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == REG_MASK) |=> mask_r == $past(reg_wdata_i[2:0]))
        else $error("mask write lost");

    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");

    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> irq_o == |(status_r & $past(mask_r)))
        else $error("interrupt level wrong");

endmodule

// ### core/dis_pkg.sv
// shared constants and types for the debounced input serializer
package dis_pkg;

    // --------------------------------------------------------------
    // geometry and timing
    // --------------------------------------------------------------
    localparam int          CHANNELS      = 8;
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          DB_LONG_MS    = 3;
    localparam int          DB_SHORT_MS   = 1;
    localparam int          DB_NONE_MS    = 0;
    localparam int          PS_PER_MS     = 1000000000;
    localparam int          DB_LONG_CYC   = (DB_LONG_MS * (PS_PER_MS / CLK_PERIOD_PS));
    localparam int          DB_SHORT_CYC  = (DB_SHORT_MS * (PS_PER_MS / CLK_PERIOD_PS));
    localparam int          DB_CNT_W      = 20;
    localparam logic [7:0]  FILT_RESET    = 8'h00;
    localparam logic [7:0]  SHIFT_RESET   = 8'h00;

    // --------------------------------------------------------------
    // debounce select codes {select_high, select_low}, 1 = open
    // --------------------------------------------------------------
    localparam logic [1:0]  DB_SEL_3MS    = 2'h3;
    localparam logic [1:0]  DB_SEL_1MS    = 2'h2;
    localparam logic [1:0]  DB_SEL_BYPASS = 2'h1;
    localparam logic [1:0]  DB_SEL_RSVD   = 2'h0;

    // --------------------------------------------------------------
    // interrupt status / mask layout
    // --------------------------------------------------------------
    localparam logic [1:0]  REG_STATUS    = 2'h0;
    localparam logic [1:0]  REG_MASK      = 2'h1;
    localparam logic [1:0]  REG_CHANNELS  = 2'h2;
    localparam int          EV_CHANGE     = 0;
    localparam int          EV_OVER_TEMP  = 1;
    localparam int          EV_SHUTDOWN   = 2;
    localparam logic [2:0]  MASK_RESET    = 3'h0;

    typedef struct packed {
        logic load_n;
        logic sclk;
        logic enable_n;
        logic sdata;
    } serial_ctl_t;

    typedef struct packed {
        logic over_temp;
        logic shutdown;
    } thermal_t;

endpackage

// ### dv/serial_ctl_model.sv
// behavioural serial controller that loads and clocks out the serializer
`timescale 1ns/1ps
module serial_ctl_model
    import dis_pkg::*;
(
    // system clock and returned data
    input  wire logic  clk_i,
    input  wire logic  sout_i,
    // controller pins
    output serial_ctl_t ctl_o
);
    initial ctl_o = '{load_n: 1'b1, sclk: 1'b0, enable_n: 1'b1, sdata: 1'b0};

    // ----------------------------------------------------------------
    // one frame: load, then sixteen shifts of 160 ns each
    // ----------------------------------------------------------------
    // sixteen shifts model a two-device chain on one controller interface
    task automatic frame(input logic [15:0] sin, input logic en_n, output logic [15:0] got);
        ctl_o.load_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        ctl_o.load_n   <= 1'b1;
        ctl_o.enable_n <= en_n;
        repeat (6) @(posedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            got[i] = sout_i;
            ctl_o.sdata <= sin[i];
            repeat (20) @(posedge clk_i);
            ctl_o.sclk <= 1'b1;
            repeat (20) @(posedge clk_i);
            ctl_o.sclk <= 1'b0;
        end
        // data line is not held between frames
        ctl_o.sdata    <= ~ctl_o.sdata;
        ctl_o.enable_n <= 1'b1;
        @(posedge clk_i);
    endtask
endmodule

// ### dv/test_debounced_input_serializer.sv
// self-checking bench for the debounced input serializer
`timescale 1ns/1ps
module test_debounced_input_serializer
    import dis_pkg::*;
;
    localparam int DB_L = 20;
    localparam int DB_S = 8;
    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  field     = 8'h00;
    logic        sel_low   = 1'b1;
    logic        sel_high  = 1'b1;
    thermal_t    therm     = '0;
    logic [1:0]  reg_addr  = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    serial_ctl_t ctl;
    logic        sout, sout_oe, tok_n, tok_oe, irq;
    logic [7:0]  rdata;
    wire         tok_pin   = tok_oe ? tok_n : 1'b0;
    int          bad_count = 0;
    int          comparisons = 0;

    always #2 clk = ~clk;

    debounced_input_serializer #(.DB_LONG(DB_L), .DB_SHORT(DB_S), .MSB_FIRST(1'b1)) i_dut (
        .clk_i(clk), .rst_b_i(rst_b), .field_inputs_i(field),
        .debounce_select_low_i(sel_low), .debounce_select_high_i(sel_high),
        .ctl_i(ctl), .serial_out_o(sout), .serial_out_oe_o(sout_oe),
        .thermal_i(therm), .temp_ok_n_o(tok_n), .temp_ok_n_oe_o(tok_oe),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .irq_o(irq));

    serial_ctl_model i_ctl (.clk_i(clk), .sout_i(sout), .ctl_o(ctl));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // read data stands only in the following cycle, so sample mid-cycle
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic close_out();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] r;
        rd(REG_MASK, r); chk(r, {5'h00, MASK_RESET});
        rd(REG_CHANNELS, r); chk(r, FILT_RESET);
        chk({sout, irq, tok_pin}, {SHIFT_RESET[7], 2'b01});
        $display("reset test done");
    endtask
    // a one-cycle glitch back to the old level restarts the count
    task automatic t_deb(input logic [1:0] sel, input int n, input logic [7:0] old, v);
        logic [7:0] r;
        {sel_high, sel_low} <= sel;
        field <= v;
        if (n > 0) begin
            repeat (n - 3) @(posedge clk);
            field <= old;
            @(posedge clk);
            field <= v;
            repeat (n - 3) @(posedge clk);
            rd(REG_CHANNELS, r); chk(r, old);
        end
        repeat (10) @(posedge clk);
        rd(REG_CHANNELS, r); chk(r, v);
        $display("debounce test done sel %h", sel);
    endtask
    task automatic t_shift();
        logic [15:0] got;
        fork
            i_ctl.frame(16'h963c, 1'b0, got);
            begin repeat (12) @(posedge clk); field <= 8'hf0; end
        join
        chk(got, 16'hc396);
        i_ctl.frame(16'h0000, 1'b1, got);
        chk(got, 16'hffff);
        $display("shift test done");
    endtask
    task automatic t_irq();
        logic [7:0] r;
        rd(REG_STATUS, r); chk(r[0], 1'b1);
        rd(REG_STATUS, r); chk({r, irq}, 9'h000);
        wr(REG_STATUS, 8'h07);
        wr(REG_MASK, 8'h01);
        field <= 8'h11;
        repeat (6) @(posedge clk);
        chk(irq, 1'b1);
        rd(2'h3, r); chk(r, 8'h00);
        rd(REG_MASK, r); chk(r, 8'h01);
        wr(REG_MASK, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(REG_STATUS, r); chk(r, 8'h01);
        @(posedge clk);
        chk(irq, 1'b0);
        $display("interrupt test done");
    endtask
    task automatic t_therm();
        logic [7:0] r;
        wr(REG_MASK, 8'h02);
        therm.over_temp <= 1'b1;
        repeat (6) @(posedge clk);
        chk({tok_pin, tok_oe, sout_oe, irq}, 4'h7);
        therm.shutdown <= 1'b1;
        repeat (6) @(posedge clk);
        chk({tok_pin, tok_oe, sout_oe}, 3'h0);
        rd(REG_STATUS, r); chk(r, 8'h06);
        therm <= '0;
        repeat (6) @(posedge clk);
        chk({tok_pin, tok_oe, sout_oe}, 3'h7);
        $display("thermal test done");
    endtask

    initial begin
        #100000;
        bad_count++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_deb(DB_SEL_3MS, DB_L, 8'h00, 8'hff);
        t_deb(DB_SEL_1MS, DB_S, 8'hff, 8'ha5);
        t_deb(DB_SEL_RSVD, DB_L, 8'ha5, 8'h5a);
        t_deb(DB_SEL_BYPASS, 0, 8'h5a, 8'hc3);
        t_shift();
        t_irq();
        t_therm();
        close_out();
    end
endmodule
